/* design/rss_regs.svh */
// register offsets, field positions, reset values and timing of the reset unit
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

`define RSS_OFS_CAUSE      12'h000
`define RSS_CAUSE_RST      16'h0001
`define RSS_CAUSE_IMPL     16'hC3FF
`define RSS_BIT_POR        0
`define RSS_BIT_BROWNOUT   1
`define RSS_BIT_IDLE       2
`define RSS_BIT_SLEEP      3
`define RSS_BIT_WDT_TO     4
`define RSS_BIT_SOFT_WDT   5
`define RSS_BIT_INSTR      6
`define RSS_BIT_PIN        7
`define RSS_BIT_REG_KEEP   8
`define RSS_BIT_CFG_MIS    9
`define RSS_BIT_ILLEGAL    14
`define RSS_BIT_TRAP       15
`define RSS_CLK_NS         25
`define RSS_PIN_MIN_NS     200
`define RSS_PIN_MIN_CYC    ((`RSS_PIN_MIN_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)

`endif

/* design/rss_pkg.sv */
// types shared by the reset source and status unit
package rss_pkg;

    // detector levels that arrive from other timing domains
    typedef struct packed {
        logic brownout_det;
        logic wdt_timeout;
        logic config_mismatch;
    } rss_det_s;

    // one-cycle events from the cpu core, same clock
    typedef struct packed {
        logic trap_conflict;
        logic illegal_access;
        logic reset_instr;
        logic sleep_wake;
        logic idle_wake;
    } rss_cpu_s;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SRC,
        ST_PULSE
    } rss_state_e;

endpackage

/* design/rss_top.sv */
// reset source merge, cause register and apb slave
//
// What this block does
// - merge all reset sources into one line
// - any active source asserts system reset
// - reset forces some bits, others keep values
// - each reset kind sets its cause flag
// - power-on clears flags, sets bit 0
// - software sets/clears flags, never causes reset
// - bit 15 flags trap-conflict reset
// - bit 14 flags illegal opcode/address/pointer
// - bits 13 to 10 read zero
// - bit 9 flags configuration mismatch reset
// - bit 8 keeps regulator active in sleep
// - bit 7 flags master clear pin reset
// - filtered low pin pulse causes reset
// - bit 6 flags reset instruction
// - bit 5 or fuse enables watchdog
// - bit 4 flags watchdog time-out
// - bit 3 flags wake from sleep
// - bit 2 flags wake from idle
// - bit 1 flags brown-out reset
// - instruction reset releases next cycle
// - instruction reset keeps current clock
`timescale 1ns/10ps
`default_nettype none
`include "rss_regs.svh"

module rss_top
#(
    parameter int PIN_MIN_CYC = `RSS_PIN_MIN_CYC
)
(
    // clock and power-on reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // reset sources
    input  wire rss_pkg::rss_det_s det,
    input  wire rss_pkg::rss_cpu_s cpu,
    input  wire logic              master_clear_pin_n,
    input  wire logic              watchdog_fuse_enable,
    // results
    output var  logic              system_reset_line,
    output var  logic              clock_reinit,
    output var  logic              watchdog_enable,
    output var  logic              regulator_sleep_keep
);

    localparam int CW = $clog2(PIN_MIN_CYC + 1);

    generate
        if (PIN_MIN_CYC < 1 || PIN_MIN_CYC > 65535)
        begin : g_bad
            $error("PIN_MIN_CYC out of range");
        end
    endgenerate

    // asynchronous inputs: fuse, pin, mismatch, watchdog, brown-out
    logic [4:0]          sync1_r;
    logic [4:0]          sync2_r;
    logic [CW-1:0]       pin_cnt_r;
    logic                pin_pass_r;
    rss_pkg::rss_state_e state_r;
    rss_pkg::rss_state_e state_nxt;
    logic [15:0]         cause_r;
    logic [15:0]         cause_nxt;
    logic                system_reset_r;
    logic                clock_reinit_r;
    logic                watchdog_enable_r;
    logic                regulator_keep_r;
    logic                pready_r;
    logic                pslverr_r;
    logic [31:0]         prdata_r;

    wire [4:0] async_in = {watchdog_fuse_enable, master_clear_pin_n,
                           det.config_mismatch, det.wdt_timeout, det.brownout_det};

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1_r <= 5'h08;
            sync2_r <= 5'h08;
        end
        else
        begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
        end
    end

    wire fuse_s     = sync2_r[4];
    wire pin_low_s  = ~sync2_r[3];
    wire cfg_mis_s  = sync2_r[2];
    wire wdt_to_s   = sync2_r[1];
    wire brownout_s = sync2_r[0];

    // glitch filter: the pin counts as asserted only after a full low run
    wire          pin_full = (pin_cnt_r == CW'(PIN_MIN_CYC));
    wire [CW-1:0] pin_cnt_nxt = !pin_low_s ? '0 :
                                pin_full   ? pin_cnt_r : pin_cnt_r + 1'b1;

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_cnt_r  <= '0;
            pin_pass_r <= 1'b0;
        end
        else
        begin
            pin_cnt_r  <= pin_cnt_nxt;
            pin_pass_r <= pin_low_s && (pin_cnt_nxt == CW'(PIN_MIN_CYC));
        end
    end

    // level sources hold the line; cpu events give a single cycle
    wire hw_rst    = brownout_s | wdt_to_s | cfg_mis_s | pin_pass_r;
    wire pulse_rst = cpu.trap_conflict | cpu.illegal_access | cpu.reset_instr;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            rss_pkg::ST_RUN:
                if (hw_rst)
                    state_nxt = rss_pkg::ST_SRC;
                else if (pulse_rst)
                    state_nxt = rss_pkg::ST_PULSE;
            rss_pkg::ST_SRC:
                if (!hw_rst)
                    state_nxt = rss_pkg::ST_RUN;
            rss_pkg::ST_PULSE:
                state_nxt = hw_rst ? rss_pkg::ST_SRC : rss_pkg::ST_RUN;
            default:
                state_nxt = rss_pkg::ST_SRC;
        endcase
    end

    // apb decode; one wait state, write lands on the edge that sees pready
    wire acc   = psel & penable;
    wire hit   = (paddr == `RSS_OFS_CAUSE);
    wire sw_wr = acc & pready_r & pwrite & hit;

    // hardware set vector; no source here sets bit 0, only power-on or a software write does
    wire [15:0] set_vec = 16'(
        ({15'h0, brownout_s}         << `RSS_BIT_BROWNOUT) |
        ({15'h0, cpu.idle_wake}      << `RSS_BIT_IDLE)     |
        ({15'h0, cpu.sleep_wake}     << `RSS_BIT_SLEEP)    |
        ({15'h0, wdt_to_s}           << `RSS_BIT_WDT_TO)   |
        ({15'h0, cpu.reset_instr}    << `RSS_BIT_INSTR)    |
        ({15'h0, pin_pass_r}         << `RSS_BIT_PIN)      |
        ({15'h0, cfg_mis_s}          << `RSS_BIT_CFG_MIS)  |
        ({15'h0, cpu.illegal_access} << `RSS_BIT_ILLEGAL)  |
        ({15'h0, cpu.trap_conflict}  << `RSS_BIT_TRAP));

    // software value first, then hardware ORs in, so an event is never lost
    wire [15:0] sw_val   = (sw_wr ? pwdata[15:0] : cause_r) & `RSS_CAUSE_IMPL;
    wire [15:0] merged   = sw_val | set_vec;
    wire [15:0] rst_mask = ~(16'h0001 << `RSS_BIT_SOFT_WDT);

    // soft watchdog enable is forced off by system reset, the rest survive
    assign cause_nxt = system_reset_r ? (merged & rst_mask) : merged;

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r           <= rss_pkg::ST_SRC;
            system_reset_r    <= 1'b1;
            clock_reinit_r    <= 1'b1;
            cause_r           <= `RSS_CAUSE_RST;
            watchdog_enable_r <= 1'b0;
            regulator_keep_r  <= 1'b0;
        end
        else
        begin
            state_r           <= state_nxt;
            system_reset_r    <= (state_nxt != rss_pkg::ST_RUN);
            clock_reinit_r    <= (state_nxt == rss_pkg::ST_SRC);
            cause_r           <= cause_nxt;
            watchdog_enable_r <= fuse_s | cause_nxt[`RSS_BIT_SOFT_WDT];
            regulator_keep_r  <= cause_nxt[`RSS_BIT_REG_KEEP];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
        else
        begin
            pready_r  <= acc & ~pready_r;
            pslverr_r <= acc & ~pready_r & ~hit;
            if (acc && !pready_r)
                prdata_r <= hit ? {16'h0000, cause_r} : 32'h0000_0000;
        end
    end

    assign prdata               = prdata_r;
    assign pready               = pready_r;
    assign pslverr              = pslverr_r;
    assign system_reset_line    = system_reset_r;
    assign clock_reinit         = clock_reinit_r;
    assign watchdog_enable      = watchdog_enable_r;
    assign regulator_sleep_keep = regulator_keep_r;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_src_asserts;
        hw_rst |=> system_reset_r;
    endproperty
    a_src_asserts: assert property (p_src_asserts) else $error("source did not reset");

    property p_instr_release;
        (state_r == rss_pkg::ST_RUN && cpu.reset_instr && !hw_rst)
            |=> system_reset_r && !clock_reinit_r ##1 (!system_reset_r || $past(hw_rst));
    endproperty
    a_instr_release: assert property (p_instr_release) else $error("instr reset length");

    property p_trap_flag;
        cpu.trap_conflict |=> cause_r[`RSS_BIT_TRAP];
    endproperty
    a_trap_flag: assert property (p_trap_flag) else $error("trap flag missing");

    property p_illegal_flag;
        cpu.illegal_access |=> cause_r[`RSS_BIT_ILLEGAL];
    endproperty
    a_illegal_flag: assert property (p_illegal_flag) else $error("illegal flag missing");

    property p_unimpl_zero;
        prdata_r[13:10] == 4'h0 && prdata_r[31:16] == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits set");

    property p_cfg_flag;
        cfg_mis_s |=> cause_r[`RSS_BIT_CFG_MIS] && system_reset_r;
    endproperty
    a_cfg_flag: assert property (p_cfg_flag) else $error("mismatch not flagged");

    property p_reg_keep;
        sw_wr |=> (regulator_keep_r == $past(pwdata[`RSS_BIT_REG_KEEP]));
    endproperty
    a_reg_keep: assert property (p_reg_keep) else $error("regulator bit mismatch");

    property p_pin_filter;
        $rose(pin_pass_r) |-> $past(pin_low_s, 1) && pin_cnt_r == CW'(PIN_MIN_CYC);
    endproperty
    a_pin_filter: assert property (p_pin_filter) else $error("short pulse passed");

    property p_fuse_wdt;
        fuse_s |=> watchdog_enable_r;
    endproperty
    a_fuse_wdt: assert property (p_fuse_wdt) else $error("fuse ignored");

    property p_hw_wins;
        (sw_wr && set_vec != 16'h0000) |=> ((cause_r & $past(set_vec)) == $past(set_vec));
    endproperty
    a_hw_wins: assert property (p_hw_wins) else $error("event lost to write");

    property p_sw_no_reset;
        (sw_wr && state_r == rss_pkg::ST_RUN && !hw_rst && !pulse_rst) |=> !system_reset_r;
    endproperty
    a_sw_no_reset: assert property (p_sw_no_reset) else $error("write caused reset");

    property p_brownout_flag;
        brownout_s |=> cause_r[`RSS_BIT_BROWNOUT] && clock_reinit_r;
    endproperty
    a_brownout_flag: assert property (p_brownout_flag) else $error("brown-out missed");

    property p_instr_flag;
        cpu.reset_instr |=> cause_r[`RSS_BIT_INSTR];
    endproperty
    a_instr_flag: assert property (p_instr_flag) else $error("instr flag missing");

    property p_sleep_flag;
        cpu.sleep_wake |=> cause_r[`RSS_BIT_SLEEP];
    endproperty
    a_sleep_flag: assert property (p_sleep_flag) else $error("sleep flag missing");

    property p_idle_flag;
        cpu.idle_wake |=> cause_r[`RSS_BIT_IDLE];
    endproperty
    a_idle_flag: assert property (p_idle_flag) else $error("idle flag missing");

    property p_wdt_flag;
        wdt_to_s |=> cause_r[`RSS_BIT_WDT_TO] && system_reset_r;
    endproperty
    a_wdt_flag: assert property (p_wdt_flag) else $error("time-out missed");

    property p_pin_flag;
        pin_pass_r |=> cause_r[`RSS_BIT_PIN] && system_reset_r;
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("pin reset missed");

    property p_por_hold;
        (!sw_wr && !cause_r[`RSS_BIT_POR]) |=> !cause_r[`RSS_BIT_POR];
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("power-on flag set");

    property p_quiet_run;
        (state_r == rss_pkg::ST_RUN && !hw_rst && !pulse_rst) |=> !system_reset_r;
    endproperty
    a_quiet_run: assert property (p_quiet_run) else $error("reset with no source");

    property p_pulse_rst;
        (pulse_rst && !system_reset_r) |=> system_reset_r;
    endproperty
    a_pulse_rst: assert property (p_pulse_rst) else $error("cpu reset missed");

    property p_release_level;
        (state_r == rss_pkg::ST_SRC && !hw_rst) |=> !system_reset_r;
    endproperty
    a_release_level: assert property (p_release_level) else $error("line held");

    property p_soft_wdt_cleared;
        system_reset_r |=> !cause_r[`RSS_BIT_SOFT_WDT];
    endproperty
    a_soft_wdt_cleared: assert property (p_soft_wdt_cleared) else $error("wdt bit kept");

    property p_keep_survives;
        (system_reset_r && !sw_wr) |=> (cause_r[`RSS_BIT_REG_KEEP] == $past(cause_r[8]));
    endproperty
    a_keep_survives: assert property (p_keep_survives) else $error("keep bit lost");

    property p_soft_wdt;
        !fuse_s |=> (watchdog_enable_r == cause_r[`RSS_BIT_SOFT_WDT]);
    endproperty
    a_soft_wdt: assert property (p_soft_wdt) else $error("soft enable ignored");

    property p_pready_pulse;
        pready_r |=> !pready_r;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready too long");

    property p_wait_state;
        (acc && !pready_r) |=> pready_r;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("no answer");

    property p_err_unmapped;
        (acc && !pready_r) |=> (pslverr_r == !$past(hit));
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("error flag wrong");

    property p_read_data;
        (acc && !pready_r && hit) |=> (prdata_r == {16'h0000, $past(cause_r)});
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");

    property p_clk_kept;
        (state_r == rss_pkg::ST_PULSE) |-> !clock_reinit_r;
    endproperty
    a_clk_kept: assert property (p_clk_kept) else $error("clock reinit on instr");

    property p_unimpl_hold;
        (cause_r & ~`RSS_CAUSE_IMPL) == 16'h0000;
    endproperty
    a_unimpl_hold: assert property (p_unimpl_hold) else $error("unimplemented bit held");

    c_pin_reset: cover property ($rose(pin_pass_r) ##1 system_reset_r);
    c_instr_reset: cover property (cpu.reset_instr ##1 system_reset_r ##1 !system_reset_r);
    c_sw_clear: cover property (sw_wr && pwdata[15:0] == 16'h0000);
    c_set_vs_write: cover property (sw_wr && set_vec != 16'h0000);
    c_level_reset: cover property (hw_rst ##1 system_reset_r && clock_reinit_r);

endmodule

`default_nettype wire

/* verif/rss_src_model.sv */
// far-side model: core events, reset detectors and master clear pin
`timescale 1ns/10ps
`default_nettype none

module rss_src_model
(
    // clock
    input  wire logic              sys_clk,
    // sources seen by the reset unit
    output var  rss_pkg::rss_det_s det,
    output var  rss_pkg::rss_cpu_s cpu,
    output var  logic              master_clear_pin_n
);
    initial
    begin
        det = '0;
        cpu = '0;
        master_clear_pin_n = 1'b1;
    end

    // one-cycle core event, index into the packed struct
    task automatic cpu_event(input int idx);
        @(posedge sys_clk);
        cpu[idx] <= 1'b1;
        @(posedge sys_clk);
        cpu <= '0;
    endtask

    task automatic det_set(input int idx, input logic v);
        @(posedge sys_clk);
        det[idx] <= v;
    endtask

    // supervisor pulls the pin low; driven high again afterwards
    task automatic pin_low(input int cyc);
        @(posedge sys_clk);
        master_clear_pin_n <= 1'b0;
        repeat (cyc) @(posedge sys_clk);
        master_clear_pin_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

/* verif/tb.sv */
// self-checking testbench of the reset source and status unit
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic              sys_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    rss_pkg::rss_det_s det;
    rss_pkg::rss_cpu_s cpu;
    logic              pin_n;
    logic              fuse = 1'b0;
    logic              rst_line;
    logic              clk_reinit;
    logic              wdt_en;
    logic              reg_keep;
    logic [31:0]       rd;
    logic              err;
    int                fail_count = 0;
    int                n_checks = 0;
    int                cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    // short filter keeps the pin scenarios brief
    rss_top #(.PIN_MIN_CYC(2)) u_rss_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .det(det), .cpu(cpu), .master_clear_pin_n(pin_n),
        .watchdog_fuse_enable(fuse), .system_reset_line(rst_line), .clock_reinit(clk_reinit),
        .watchdog_enable(wdt_en), .regulator_sleep_keep(reg_keep));

    rss_src_model u_rss_src_model (.sys_clk(sys_clk), .det(det), .cpu(cpu),
        .master_clear_pin_n(pin_n));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; no wait count assumed, only a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        chk("pready", pready, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_line(input logic v);
        int n;
        n = 0;
        while (rst_line !== v && n < 30)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk("cause_por", rd, 32'h0000_0001);
        apb(1'b1, 12'h000, 32'hFFFF_FFFF);
        repeat (3) @(negedge sys_clk);
        chk("sw_set_line", rst_line, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk("cause_all", rd, 32'h0000_C3FF);
        chk("reg_keep", reg_keep, 32'h1);
        chk("wdt_soft", wdt_en, 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk("cause_clr", rd, 32'h0);
        chk("reg_standby", reg_keep, 32'h0);
        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        chk("unmap_wr_err", err, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk("unmap_rd", rd, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk("unmap_no_effect", rd, 32'h0);
    endtask

    task automatic t_cpu;
        int idx[5] = '{4, 3, 2, 1, 0};
        int pos[5] = '{15, 14, 6, 3, 2};
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, 12'h000, 32'h0);
            u_rss_src_model.cpu_event(idx[i]);
            @(negedge sys_clk);
            chk("cpu_line", rst_line, (i < 3) ? 32'h1 : 32'h0);
            chk("clk_kept", clk_reinit, 32'h0);
            @(negedge sys_clk);
            chk("cpu_release", rst_line, 32'h0);
            apb(1'b0, 12'h000, 32'h0);
            chk("cpu_flag", rd, 32'h1 << pos[i]);
        end
    endtask

    task automatic t_level;
        int pos[3] = '{1, 4, 9};
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, 12'h000, 32'h0000_0120);
            u_rss_src_model.det_set(2 - i, 1'b1);
            wait_line(1'b1);
            chk("level_line", rst_line, 32'h1);
            chk("clk_reinit", clk_reinit, 32'h1);
            apb(1'b0, 12'h000, 32'h0);
            chk("level_flag", rd, 32'h0000_0100 | (32'h1 << pos[i]));
            apb(1'b1, 12'h000, 32'h0);
            apb(1'b0, 12'h000, 32'h0);
            chk("hw_wins", rd, 32'h1 << pos[i]);
            u_rss_src_model.det_set(2 - i, 1'b0);
            wait_line(1'b0);
            chk("level_release", rst_line, 32'h0);
        end
    endtask

    task automatic t_pin;
        int hits;
        hits = 0;
        apb(1'b1, 12'h000, 32'h0);
        u_rss_src_model.pin_low(1);
        repeat (10)
        begin
            @(negedge sys_clk);
            if (rst_line !== 1'b0)
                hits++;
        end
        chk("pin_glitch", hits, 32'h0);
        u_rss_src_model.pin_low(6);
        wait_line(1'b1);
        chk("pin_line", rst_line, 32'h1);
        wait_line(1'b0);
        apb(1'b0, 12'h000, 32'h0);
        chk("pin_flag", rd, 32'h0000_0080);
    endtask

    task automatic t_fuse;
        apb(1'b1, 12'h000, 32'h0);
        fuse <= 1'b1;
        repeat (5) @(negedge sys_clk);
        chk("fuse_wdt", wdt_en, 32'h1);
        @(posedge sys_clk);
        fuse <= 1'b0;
        repeat (5) @(negedge sys_clk);
        chk("fuse_off", wdt_en, 32'h0);
    endtask

    // mid-run power-on reset: flags set before must give way to bit 0 alone
    task automatic t_por;
        apb(1'b1, 12'h000, 32'h0000_C3FF);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("por_line", rst_line, 32'h1);
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk("por_cause", rd, 32'h0000_0001);
        chk("por_keep", reg_keep, 32'h0);
        chk("por_wdt", wdt_en, 32'h0);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            end_sim();
        end
    end

    initial
    begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("line_in_reset", rst_line, 32'h1);
        chk("wdt_in_reset", wdt_en, 32'h0);
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_cpu();
        t_level();
        t_pin();
        t_fuse();
        t_por();
        end_sim();
    end
endmodule

`default_nettype wire
